/* src/usps_pkg.sv */
// Constants and helper functions of the unipolar stepper phase sequencer
//
// Function
// - One-pulse: one step, direction from level
// - Two-pulse: forward input forward, reverse input reverse
// - First input forward/step, second reverse/direction
// - Format switch selects; two-pulse is default
// - Full step two phases, half step alternates
// - Default step switch: high or open gives full
// - Excitation input with polarity switch releases phases
// - Default excitation switch: high or open energizes
// - Activity lamp lights with each phase advance
// - Act on rising edge, ignore falling edge
// - Default direction: low forward, high reverse
// - Default: high selects full, low selects half
// - Default: high holds shaft, low frees it
package usps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned PULSE_MIN_US = 10;
    // Lamp flash stretched to the minimum pulse width so each step is seen
    localparam int unsigned LAMP_TIME_US = PULSE_MIN_US;
    localparam int unsigned LAMP_CNT_W = 11;
    localparam logic [LAMP_CNT_W-1:0] LAMP_CYCLES =
        LAMP_CNT_W'((LAMP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [LAMP_CNT_W-1:0] LAMP_CNT_RST = 11'h000;

    // ------------------------------------------------------------
    // Synchronized input bit positions
    // ------------------------------------------------------------
    localparam int unsigned IN_FWD = 0;
    localparam int unsigned IN_REV = 1;
    localparam int unsigned IN_SIZE = 2;
    localparam int unsigned IN_EXC = 3;
    localparam int unsigned IN_FMT_SW = 4;
    localparam int unsigned IN_SIZE_SW = 5;
    localparam int unsigned IN_EXC_SW = 6;
    localparam int unsigned IN_W = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Synchronizers start at the open-pin and default-switch levels
    localparam logic [IN_W-1:0] SYNC_RST = 7'h2C;
    localparam logic [1:0] EDGE_RST = 2'h0;
    // Odd index is a two-phase state, so full stepping starts aligned
    localparam logic [2:0] IDX_RST = 3'h1;
    localparam logic [3:0] PHASE_RST = 4'h0;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Outputs ordered {phase4, phase3, phase2, phase1}
    function automatic logic [3:0] phase_pattern(input logic [2:0] idx);
        logic [3:0] p;
        p = 4'h0;
        unique case (idx)
            3'h0: p = 4'h1;
            3'h1: p = 4'h3;
            3'h2: p = 4'h2;
            3'h3: p = 4'h6;
            3'h4: p = 4'h4;
            3'h5: p = 4'hC;
            3'h6: p = 4'h8;
            3'h7: p = 4'h9;
        endcase
        return p;
    endfunction : phase_pattern

    // A full step from a one-phase state moves half a step to realign
    function automatic logic [2:0] next_idx(input logic [2:0] idx, input logic fwd, input logic full);
        logic [2:0] d;
        d = (full && idx[0]) ? 3'h2 : 3'h1;
        return fwd ? 3'(idx + d) : 3'(idx - d);
    endfunction : next_idx

endpackage : usps_pkg

/* src/usps_top.sv */
// Step command decoder and four-phase sequencer with activity lamp
`timescale 1ns/1ps
module usps_top (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    // Command inputs
    input wire logic I_FORWARD_OR_STEP_INPUT,
    input wire logic I_REVERSE_OR_HEADING_INPUT,
    // Control levels
    input wire logic I_STEP_SIZE_SELECT,
    input wire logic I_EXCITATION_CONTROL_PIN,
    // Board switches
    input wire logic I_COMMAND_FORMAT_SWITCH,
    input wire logic I_STEP_SIZE_POLARITY_SWITCH,
    input wire logic I_EXCITATION_POLARITY_SWITCH,
    // Motor phases
    output logic [3:0] O_PHASE,
    // Lamps
    output logic O_LOGIC_POWER_LAMP,
    output logic O_MOTION_ACTIVITY_LAMP
);

    // ------------------------------------------------------------
    // Input synchronization
    // ------------------------------------------------------------
    logic [usps_pkg::IN_W-1:0] pins;
    logic [usps_pkg::IN_W-1:0] sync1_r;
    logic [usps_pkg::IN_W-1:0] sync2_r;
    logic [1:0] prev_r;
    logic [1:0] rise;
    logic [1:0] fall;

    assign pins = {I_EXCITATION_POLARITY_SWITCH, I_STEP_SIZE_POLARITY_SWITCH, I_COMMAND_FORMAT_SWITCH,
                   I_EXCITATION_CONTROL_PIN, I_STEP_SIZE_SELECT,
                   I_REVERSE_OR_HEADING_INPUT, I_FORWARD_OR_STEP_INPUT};

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            sync1_r <= usps_pkg::SYNC_RST;
            sync2_r <= usps_pkg::SYNC_RST;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            prev_r <= usps_pkg::EDGE_RST;
        end else begin
            prev_r <= sync2_r[1:0];
        end
    end

    assign rise = sync2_r[1:0] & ~prev_r;
    assign fall = ~sync2_r[1:0] & prev_r;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic one_pulse;
    logic full_sel;
    logic energized;

    assign one_pulse = sync2_r[usps_pkg::IN_FMT_SW];
    assign full_sel = ~(sync2_r[usps_pkg::IN_SIZE] ^ sync2_r[usps_pkg::IN_SIZE_SW]);
    assign energized = sync2_r[usps_pkg::IN_EXC] ^ sync2_r[usps_pkg::IN_EXC_SW];

    // ------------------------------------------------------------
    // Step decode
    // ------------------------------------------------------------
    logic step_fire;
    logic step_fwd;

    always_comb begin
        if (one_pulse) begin
            step_fire = rise[0];
            step_fwd = ~sync2_r[usps_pkg::IN_REV];
        end else begin
            // Simultaneous forward and reverse edges cancel
            step_fire = rise[0] ^ rise[1];
            step_fwd = rise[0];
        end
        // Pulses while released are dropped, the phase index stays put
        step_fire = step_fire & energized;
    end

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    logic [2:0] idx_r;
    logic [2:0] idx_nxt;
    logic [3:0] phase_r;

    assign idx_nxt = step_fire ? usps_pkg::next_idx(idx_r, step_fwd, full_sel) : idx_r;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            idx_r <= usps_pkg::IDX_RST;
        end else begin
            idx_r <= idx_nxt;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            phase_r <= usps_pkg::PHASE_RST;
        end else begin
            phase_r <= energized ? usps_pkg::phase_pattern(idx_nxt) : usps_pkg::PHASE_RST;
        end
    end

    assign O_PHASE = phase_r;

    // ------------------------------------------------------------
    // Lamps
    // ------------------------------------------------------------
    logic [usps_pkg::LAMP_CNT_W-1:0] lamp_cnt_r;
    logic lamp_r;
    logic power_r;

    // Stretch lamp on each advance
    // Retriggered by every step, so a fast pulse train keeps it lit
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            lamp_cnt_r <= usps_pkg::LAMP_CNT_RST;
        end else if (step_fire) begin
            lamp_cnt_r <= usps_pkg::LAMP_CYCLES;
        end else if (lamp_cnt_r != usps_pkg::LAMP_CNT_RST) begin
            lamp_cnt_r <= lamp_cnt_r - 11'h001;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            lamp_r <= 1'h0;
        end else begin
            lamp_r <= step_fire || (lamp_cnt_r > 11'h001);
        end
    end

    // Power lamp only shows that the logic is out of reset
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            power_r <= 1'h0;
        end else begin
            power_r <= 1'h1;
        end
    end

    assign O_MOTION_ACTIVITY_LAMP = lamp_r;
    assign O_LOGIC_POWER_LAMP = power_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_lamp_flash;
        O_MOTION_ACTIVITY_LAMP [*8];
    endsequence

    sequence s_moved;
        idx_r != $past(idx_r);
    endsequence

    a_one_pulse_dir: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        one_pulse && rise[0] && energized
        |=> idx_r == usps_pkg::next_idx($past(idx_r), !$past(sync2_r[usps_pkg::IN_REV]), $past(full_sel)))
        else $error("one-pulse step or direction wrong");

    a_two_pulse_fwd: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        !one_pulse && energized && rise[0] && !rise[1]
        |=> idx_r == usps_pkg::next_idx($past(idx_r), 1'h1, $past(full_sel)))
        else $error("forward pulse did not step forward");

    a_two_pulse_rev: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        !one_pulse && energized && rise[1] && !rise[0]
        |=> idx_r == usps_pkg::next_idx($past(idx_r), 1'h0, $past(full_sel)))
        else $error("reverse pulse did not step in reverse");

    a_full_two_on: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        step_fire && full_sel |=> $countones(O_PHASE) == 2)
        else $error("full step did not energize two phases");

    a_half_alternate: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        step_fire && !full_sel |=> idx_r[0] != $past(idx_r[0]))
        else $error("half step did not alternate phase count");

    a_default_size: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        sync2_r[usps_pkg::IN_SIZE_SW] |-> full_sel == sync2_r[usps_pkg::IN_SIZE])
        else $error("default step size polarity wrong");

    a_release_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        !energized |=> O_PHASE == 4'h0 && $stable(idx_r))
        else $error("phases not released or index moved while off");

    a_default_exc: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        !sync2_r[usps_pkg::IN_EXC_SW] && sync2_r[usps_pkg::IN_EXC] |=> O_PHASE != 4'h0)
        else $error("default excitation did not energize");

    a_lamp_on_step: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        step_fire |=> s_moved ##0 s_lamp_flash)
        else $error("lamp not lit with phase advance");

    a_fall_ignored: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        fall != 2'h0 && rise == 2'h0 |-> !step_fire)
        else $error("falling edge produced a step");

    // Back-to-back steps may only come from the two different inputs
    a_one_step_each: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        step_fire |=> !step_fire || (step_fwd != $past(step_fwd)))
        else $error("one pulse produced two steps");

endmodule : usps_top

/* tb/usps_host_model.sv */
// Host pulse generator model driving the command and control pins
`timescale 1ns/1ps
module usps_host_model (
    // Clock
    input wire logic i_clk,
    // Pins towards the sequencer
    output logic o_fwd,
    output logic o_rev,
    output logic o_size,
    output logic o_exc
);
    // Width and setup kept just over the minimum, so a real host is matched
    localparam int HOLD_CYC = 2001;

    initial begin
        o_fwd = 1'b0;
        o_rev = 1'b0;
        o_size = 1'b1;
        o_exc = 1'b1;
    end

    task automatic prep(input logic rev_lvl, input logic size_lvl);
        @(negedge i_clk);
        o_rev = rev_lvl;
        o_size = size_lvl;
        repeat (HOLD_CYC) @(negedge i_clk);
    endtask : prep

    task automatic rise(input logic on_rev);
        if (on_rev) begin
            o_rev = 1'b1;
        end else begin
            o_fwd = 1'b1;
        end
    endtask : rise

    task automatic fall(input logic on_rev);
        repeat (HOLD_CYC - 5) @(negedge i_clk);
        if (on_rev) begin
            o_rev = 1'b0;
        end else begin
            o_fwd = 1'b0;
        end
        repeat (HOLD_CYC) @(negedge i_clk);
    endtask : fall

    task automatic set_exc(input logic v);
        @(negedge i_clk);
        o_exc = v;
        repeat (5) @(negedge i_clk);
    endtask : set_exc
endmodule : usps_host_model

/* tb/tb.sv */
// Self-checking bench of the stepper phase sequencer
`timescale 1ns/1ps
module tb;
    logic I_SYS_CLK = 1'b0;
    logic I_RSTN = 1'b0;
    logic fwd, rev, size, exc;
    logic fmt_sw = 1'b0;
    logic size_sw = 1'b1;
    logic exc_sw = 1'b0;
    logic [3:0] O_PHASE;
    logic O_LOGIC_POWER_LAMP, O_MOTION_ACTIVITY_LAMP;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int idx = 1;
    logic en = 1'b1;
    logic [3:0] tbl [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};

    always #2.5 I_SYS_CLK = ~I_SYS_CLK;

    usps_host_model u_usps_host_model (.i_clk(I_SYS_CLK), .o_fwd(fwd), .o_rev(rev), .o_size(size), .o_exc(exc));
    usps_top u_usps_top (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_FORWARD_OR_STEP_INPUT(fwd),
        .I_REVERSE_OR_HEADING_INPUT(rev), .I_STEP_SIZE_SELECT(size), .I_EXCITATION_CONTROL_PIN(exc),
        .I_COMMAND_FORMAT_SWITCH(fmt_sw), .I_STEP_SIZE_POLARITY_SWITCH(size_sw),
        .I_EXCITATION_POLARITY_SWITCH(exc_sw), .O_PHASE(O_PHASE), .O_LOGIC_POWER_LAMP(O_LOGIC_POWER_LAMP),
        .O_MOTION_ACTIVITY_LAMP(O_MOTION_ACTIVITY_LAMP));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (exp !== got) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // Nine pulses of about 6000 cycles each, with margin
    always @(posedge I_SYS_CLK) begin
        cyc++;
        if (cyc == 70000) begin
            err_count++;
            wrap_up();
        end
    end

    // One command pulse; full step from an even index realigns by one
    task automatic step(input logic on_rev, input logic rev_lvl, input logic size_lvl, input logic dir_fwd,
                        input logic full, input logic moves);
        int d;
        u_usps_host_model.prep(rev_lvl, size_lvl);
        u_usps_host_model.rise(on_rev);
        d = (full && idx[0]) ? 2 : 1;
        if (moves) begin
            idx = dir_fwd ? (idx + d) % 8 : (idx + 8 - d) % 8;
        end
        repeat (5) @(negedge I_SYS_CLK);
        check("phase after rise", en ? tbl[idx] : 4'h0, O_PHASE);
        check("activity lamp", {3'h0, moves}, {3'h0, O_MOTION_ACTIVITY_LAMP});
        u_usps_host_model.fall(on_rev);
        check("phase after fall", en ? tbl[idx] : 4'h0, O_PHASE);
    endtask : step

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge I_SYS_CLK);
        I_RSTN = 1'b1;
        repeat (5) @(negedge I_SYS_CLK);
        check("phase at start", 4'h3, O_PHASE);
        check("power lamp", 4'h1, {3'h0, O_LOGIC_POWER_LAMP});
        step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        step(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        step(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        size_sw = 1'b0;
        step(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        size_sw = 1'b1;
        fmt_sw = 1'b1;
        step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        step(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        u_usps_host_model.set_exc(1'b0);
        en = 1'b0;
        check("phase released", 4'h0, O_PHASE);
        step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        u_usps_host_model.set_exc(1'b1);
        en = 1'b1;
        check("phase held", tbl[idx], O_PHASE);
        exc_sw = 1'b1;
        repeat (6) @(negedge I_SYS_CLK);
        check("phase inverted off", 4'h0, O_PHASE);
        exc_sw = 1'b0;
        wrap_up();
    end
endmodule : tb
